// >>> rtl/nvsac_ctrl.sv
// Host-side controller for the battery-backed SRAM module's strobe pins.
// Assumes one request port on the clock, an external supply monitor on
// power_fail_i, and the module's pins wired directly to the mem_ ports.
`default_nettype none
`include "nvsac_defines.svh"
module nvsac_ctrl
  import nvsac_pkg::*;
#(
  parameter int ADDR_W = `NVSAC_ADDR_W,
  parameter int DATA_W = `NVSAC_DATA_W,
  parameter logic [`NVSAC_TMR_W-1:0] PWRUP_CYCLES = `NVSAC_TMR_W'(`NVSAC_LOCKOUT_CYC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // User request port
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  output logic locked_o,
  // Supply monitor
  input wire logic power_fail_i,
  // Memory pins
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic mem_ce_n_o,
  output logic mem_we_n_o,
  output logic mem_oe_n_o,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_o,
  input wire logic [DATA_W-1:0] mem_dq_i
);
  // ********************************************************************
  // State and lockout timer
  // ********************************************************************
  nvsac_ctrl_t s_reg;
  nvsac_ctrl_t s_next;
  nvsac_tmr_if tmr_if ();

  nvsac_timer u_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .t(tmr_if.tmr)
  );

  assign tmr_if.load = s_reg.tmr_load;
  assign tmr_if.load_val = PWRUP_CYCLES;

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.pf_s1 = power_fail_i;
    s_next.pf_s2 = s_reg.pf_s1;
    s_next.dq_s1 = mem_dq_i;
    s_next.dq_s2 = s_reg.dq_s1;
    s_next.tmr_load = 1'b0;
    s_next.rsp_valid = 1'b0;
    case (s_reg.st)
      NVSAC_ST_START: begin
        // Reset is taken as a fresh power-up, so the lockout is run first
        s_next.tmr_load = 1'b1;
        s_next.locked = 1'b1;
        s_next.st = NVSAC_ST_LOCK;
      end
      NVSAC_ST_LOCK: begin
        // No strobe activity while the module is write-protected
        if (s_reg.pf_s2) begin
          s_next.st = NVSAC_ST_START;
        end else if (!s_reg.tmr_load && !tmr_if.busy) begin
          s_next.locked = 1'b0;
          s_next.st = NVSAC_ST_IDLE;
        end
      end
      NVSAC_ST_IDLE: begin
        // A request seen with ready high is honoured even if power fail lands
        // in the same cycle; it ends well under the 2 us margin
        if (req_i && s_reg.ready) begin
          // Address moves only with both strobes high
          s_next.addr = req_addr_i;
          s_next.write = req_write_i;
          s_next.dq_out = req_wdata_i;
          s_next.st = NVSAC_ST_SETUP;
        end else if (s_reg.pf_s2 || !s_reg.ready) begin
          // Ready low in idle only follows a power fail seen in the END cycle, so a short one there is not lost
          s_next.locked = 1'b1;
          s_next.st = NVSAC_ST_LOCK;
        end
      end
      NVSAC_ST_SETUP: begin
        // Address has stood a full cycle before chip-select falls
        s_next.ce_n = 1'b0;
        s_next.cnt = '0;
        if (s_reg.write) begin
          // Chip-select and strobe fall together; data drive rises with them, output-enable stays high
          s_next.we_n = 1'b0;
          s_next.dq_oe = 1'b1;
          s_next.st = NVSAC_ST_WR_PULSE;
        end else begin
          s_next.oe_n = 1'b0;
          s_next.st = NVSAC_ST_RD_WAIT;
        end
      end
      NVSAC_ST_RD_WAIT: begin
        s_next.cnt = s_reg.cnt + `NVSAC_CNT_W'(1);
        if (s_reg.cnt == `NVSAC_CNT_W'(`NVSAC_ACCESS_CYC + `NVSAC_SYNC_CYC - 1)) begin
          s_next.rdata = s_reg.dq_s2;
          s_next.rsp_valid = 1'b1;
          s_next.ce_n = 1'b1;
          s_next.oe_n = 1'b1;
          s_next.st = NVSAC_ST_END;
        end
      end
      NVSAC_ST_WR_PULSE: begin
        s_next.cnt = s_reg.cnt + `NVSAC_CNT_W'(1);
        if (s_reg.cnt == `NVSAC_CNT_W'(`NVSAC_WPULSE_CYC - 1)) begin
          // Strobe rises first and ends the write; data still driven
          s_next.we_n = 1'b1;
          s_next.st = NVSAC_ST_WR_HOLD;
        end
      end
      NVSAC_ST_WR_HOLD: begin
        s_next.ce_n = 1'b1;
        s_next.st = NVSAC_ST_END;
      end
      NVSAC_ST_END: begin
        // Recovery cycle; data released only after both strobes are high
        s_next.dq_oe = 1'b0;
        s_next.st = NVSAC_ST_IDLE;
      end
      default: begin
        s_next.st = NVSAC_ST_START;
      end
    endcase
    // Only the second synchroniser stage is read here
    s_next.ready = (s_next.st == NVSAC_ST_IDLE) && !s_reg.pf_s2;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
      s_reg.st <= NVSAC_ST_START;
      s_reg.ce_n <= 1'b1;
      s_reg.we_n <= 1'b1;
      s_reg.oe_n <= 1'b1;
      s_reg.locked <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ********************************************************************
  // Outputs, all from the state register
  // ********************************************************************
  assign req_ready_o = s_reg.ready;
  assign rsp_valid_o = s_reg.rsp_valid;
  assign rsp_rdata_o = s_reg.rdata;
  assign locked_o = s_reg.locked;
  assign mem_addr_o = s_reg.addr;
  assign mem_ce_n_o = s_reg.ce_n;
  assign mem_we_n_o = s_reg.we_n;
  assign mem_oe_n_o = s_reg.oe_n;
  assign mem_dq_o = s_reg.dq_out;
  assign mem_dq_oe_o = s_reg.dq_oe;
endmodule
`default_nettype wire

// >>> rtl/nvsac_defines.svh
// Constants of the host-side controller for the battery-backed SRAM module.
// Assumes a single 10 MHz clock and the module's asynchronous strobe pins.
`ifndef NVSAC_DEFINES_SVH
`define NVSAC_DEFINES_SVH

`define NVSAC_ADDR_W 15
`define NVSAC_DATA_W 8
`define NVSAC_CLK_NS 100
// Least access time and write pulse width of the module, in ns
`define NVSAC_ACCESS_NS 85
`define NVSAC_WPULSE_NS 65
// Least cycle counts, rounded up
`define NVSAC_ACCESS_CYC ((`NVSAC_ACCESS_NS + `NVSAC_CLK_NS - 1) / `NVSAC_CLK_NS)
`define NVSAC_WPULSE_CYC ((`NVSAC_WPULSE_NS + `NVSAC_CLK_NS - 1) / `NVSAC_CLK_NS)
// Two extra cycles for the data synchroniser
`define NVSAC_SYNC_CYC 2
`define NVSAC_CNT_W 3
// Power-up lockout, longest figure in ms
`define NVSAC_LOCKOUT_MS 200
`define NVSAC_LOCKOUT_CYC ((`NVSAC_LOCKOUT_MS * 1000000) / `NVSAC_CLK_NS)
`define NVSAC_TMR_W 21

`endif

// >>> rtl/nvsac_pkg.sv
// Types shared by the controller and its lockout timer.
// Assumes the constants header sits beside it.
`default_nettype none
`include "nvsac_defines.svh"
package nvsac_pkg;
  typedef enum logic [2:0] {
    NVSAC_ST_START,
    NVSAC_ST_LOCK,
    NVSAC_ST_IDLE,
    NVSAC_ST_SETUP,
    NVSAC_ST_RD_WAIT,
    NVSAC_ST_WR_PULSE,
    NVSAC_ST_WR_HOLD,
    NVSAC_ST_END
  } nvsac_state_t;

  typedef struct packed {
    nvsac_state_t st;
    logic write;
    logic [`NVSAC_ADDR_W-1:0] addr;
    logic [`NVSAC_DATA_W-1:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic ready;
    logic rsp_valid;
    logic [`NVSAC_DATA_W-1:0] rdata;
    logic locked;
    logic [`NVSAC_CNT_W-1:0] cnt;
    logic pf_s1;
    logic pf_s2;
    logic [`NVSAC_DATA_W-1:0] dq_s1;
    logic [`NVSAC_DATA_W-1:0] dq_s2;
    logic tmr_load;
  } nvsac_ctrl_t;

  typedef struct packed {
    logic [`NVSAC_TMR_W-1:0] cnt;
    logic busy;
  } nvsac_tmr_t;
endpackage
`default_nettype wire

// >>> rtl/nvsac_tmr_if.sv
// Link between the controller and its lockout timer.
// Assumes both ends run on the same clock.
`default_nettype none
`include "nvsac_defines.svh"
interface nvsac_tmr_if;
  logic load;
  logic [`NVSAC_TMR_W-1:0] load_val;
  logic busy;
  modport ctrl (output load, output load_val, input busy);
  modport tmr (input load, input load_val, output busy);
endinterface
`default_nettype wire

// >>> rtl/nvsac_timer.sv
// Down-counter that measures the power-up write lockout.
// Assumes load is a one-cycle pulse from the controller.
`default_nettype none
`include "nvsac_defines.svh"
module nvsac_timer
  import nvsac_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Controller side
  nvsac_tmr_if.tmr t
);
  nvsac_tmr_t s_reg;
  nvsac_tmr_t s_next;

  always_comb begin
    s_next = s_reg;
    if (t.load) begin
      s_next.cnt = t.load_val;
      s_next.busy = 1'b1;
    end else if (s_reg.busy) begin
      s_next.cnt = s_reg.cnt - `NVSAC_TMR_W'(1);
      if (s_reg.cnt <= `NVSAC_TMR_W'(1)) begin
        s_next.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign t.busy = s_reg.busy;
endmodule
`default_nettype wire

// >>> verification/nvsac_sram_model.sv
// Behavioural model of the battery-backed SRAM module at the pins.
// Assumes the bench resolves the data wire through dq_o.
`default_nettype none
module nvsac_sram_model #(
  parameter int ACC_NS = 85,
  parameter int WPT_NS = 2000,
  parameter int REC_NS = 1500
) (
  // Clock for the float pattern only
  input wire logic clk_i,
  // Pins
  input wire logic [14:0] addr_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] host_dq_i,
  input wire logic host_oe_i,
  input wire logic supply_low_i,
  output logic [7:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Array and protection
  // ****
  logic [7:0] mem [32768];
  logic prot = 1;
  logic hz = 0;
  logic tog = 0;
  wire logic wr = !ce_n_i && !we_n_i && !prot;
  wire logic drv;
  // Slow turn-off too: an early host drive overlaps the module drive, and dq_o shows the host value
  assign #(ACC_NS) drv = !ce_n_i && !oe_n_i && we_n_i && !hz && !prot;
  initial #(REC_NS) prot = 0;
  always @(posedge supply_low_i) begin
    #(WPT_NS);
    prot = supply_low_i;
  end
  always @(negedge supply_low_i) begin
    #(REC_NS);
    prot = supply_low_i;
  end
  always @(ce_n_i, we_n_i) hz = !ce_n_i && (hz || !we_n_i);
  // Latch the resolved wire, so a host that forgot to drive stores the float pattern
  always @(negedge wr) if (!prot) mem[addr_i] = dq_o;
  always @(posedge clk_i) tog <= ~tog;
  // Released wire never keeps its last value
  assign dq_o = host_oe_i ? host_dq_i : drv ? mem[addr_i] : {4{tog, ~tog}};
endmodule
`default_nettype wire

// >>> verification/nvsac_ctrl_assertions.sv
// Pin-protocol checks on the host-side SRAM controller.
// Assumes binding to nvsac_ctrl and one clock domain.
`default_nettype none
module nvsac_ctrl_chk #(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic locked_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic mem_ce_n_o,
  input wire logic mem_we_n_o,
  input wire logic mem_oe_n_o,
  input wire logic [DATA_W-1:0] mem_dq_o,
  input wire logic mem_dq_oe_o
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rd_we_high_a:
  assert property (!mem_ce_n_o && !mem_oe_n_o |-> mem_we_n_o) else $error("strobe low in read");
  rd_timing_a:
  assert property (req_i && req_ready_o && !req_write_i |-> ##2
    (!mem_ce_n_o && !mem_oe_n_o && mem_we_n_o) [*3] ##1 rsp_valid_o) else $error("read walk");
  addr_first_a:
  assert property ($fell(mem_ce_n_o) |-> $stable(mem_addr_o)) else $error("late address");
  addr_safe_a:
  assert property (!$stable(mem_addr_o) |-> mem_ce_n_o || mem_we_n_o) else $error("addr moved");
  no_fight_a:
  assert property (!mem_oe_n_o |-> !mem_dq_oe_o) else $error("data fight");
  wr_walk_a:
  assert property (req_i && req_ready_o && req_write_i |-> ##2 !mem_ce_n_o && !mem_we_n_o
    && mem_oe_n_o && mem_dq_oe_o && mem_dq_o == $past(req_wdata_i, 2)) else $error("write walk");
  dq_release_a:
  assert property ($fell(mem_dq_oe_o) |-> mem_ce_n_o && mem_we_n_o) else $error("early release");
  lock_quiet_a:
  assert property (locked_o |-> mem_ce_n_o && mem_we_n_o && !mem_dq_oe_o)
    else $error("strobe while locked");
endmodule
bind nvsac_ctrl nvsac_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clk_i, .resetn_i,
  .req_i, .req_write_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .locked_o, .mem_addr_o,
  .mem_ce_n_o,
  .mem_we_n_o, .mem_oe_n_o, .mem_dq_o, .mem_dq_oe_o);
`default_nettype wire

// >>> verification/nvsac_ctrl_bench.sv
// Self-checking bench of the SRAM controller against the module model.
// Assumes the checker is bound and a short power-up lockout.
`default_nettype none
module nvsac_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, resetn_i = 0, req_i = 0, req_write_i = 0, power_fail_i = 0;
  logic [14:0] req_addr_i = 15'h0000, mem_addr_o;
  logic [7:0] req_wdata_i = 8'h00, rsp_rdata_o, mem_dq_o, dq;
  logic req_ready_o, rsp_valid_o, locked_o, mem_ce_n_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_o;
  int n_fail = 0, comparisons = 0, cyc = 0;
  initial forever #50 clk_i = ~clk_i;
  nvsac_ctrl #(.PWRUP_CYCLES(21'h14)) dut (.clk_i, .resetn_i, .req_i, .req_write_i,
    .req_addr_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .locked_o,
    .power_fail_i, .mem_addr_o, .mem_ce_n_o, .mem_we_n_o, .mem_oe_n_o, .mem_dq_o,
    .mem_dq_oe_o, .mem_dq_i(dq));
  nvsac_sram_model mdl (.clk_i, .addr_i(mem_addr_o), .ce_n_i(mem_ce_n_o), .we_n_i(mem_we_n_o),
    .oe_n_i(mem_oe_n_o), .host_dq_i(mem_dq_o), .host_oe_i(mem_dq_oe_o),
    .supply_low_i(power_fail_i), .dq_o(dq));
  // ****
  // Tasks
  // ****
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic w, input logic [14:0] a, input logic [7:0] d);
    for (int i = 0; i < 60 && req_ready_o !== 1'b1; i++) @(negedge clk_i);
    {req_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, w, a, d};
    @(negedge clk_i) req_i = 0;
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    go(0, a, 8'h00);
    for (int i = 0; i < 9 && rsp_valid_o !== 1'b1; i++) @(negedge clk_i);
    chk({7'h00, rsp_valid_o}, 8'h01);
    chk(rsp_rdata_o, exp);
  endtask
  task automatic t_lock;
    chk({7'h00, locked_o}, 8'h01);
    repeat (10) @(negedge clk_i);
    chk({7'h00, req_ready_o}, 8'h00);
  endtask
  task automatic t_rw;
    logic [14:0] a[3] = '{15'h0000, 15'h7FFF, 15'h2AAA};
    for (int i = 0; i < 3; i++) go(1, a[i], 8'hA5 ^ 8'(i * 8'h33));
    for (int i = 0; i < 3; i++) rd(a[i], 8'hA5 ^ 8'(i * 8'h33));
    go(1, 15'h7FFF, 8'h0F);
    rd(15'h7FFF, 8'h0F);
  endtask
  task automatic t_pf;
    power_fail_i = 1;
    repeat (30) @(negedge clk_i);
    chk({6'h00, locked_o, req_ready_o}, 8'h02);
    power_fail_i = 0;
    rd(15'h2AAA, 8'hA5 ^ 8'h66);
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (4) @(negedge clk_i);
    resetn_i = 1;
    t_lock;
    t_rw;
    t_pf;
    close_out;
  end
  // Whole run is under two hundred cycles
  always @(posedge clk_i) if (++cyc == 2000) begin
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
